// ==== roc_counter.sv ====
// Cumulative occurrence counter with clear, saturating at full scale.
`default_nettype none
module roc_counter #(
  parameter int unsigned W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic inc,
  input wire logic clr,
  output logic [W-1:0] count
);

  // An occurrence in the clearing cycle is kept, so none is lost.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clr) begin
      count <= W'(inc);
    end else if (inc && (count != {W{1'b1}})) begin
      count <= count + W'(1);
    end
  end

endmodule
`default_nettype wire

// ==== roc_partner.sv ====
// Model of the blocking matrix, measurement feed and event buffer.
`default_nettype none
module roc_partner (
  input wire logic mclk,
  input wire logic rst,
  input wire logic blk_cmd,
  input wire logic [15:0] ratio_cmd,
  input wire roc_pkg::roc_event_s event_o,
  output logic block_in,
  output roc_pkg::roc_meas_s meas,
  output logic [15:0] inv_time,
  output logic [31:0] time_stamp,
  output logic [5:0][7:0] ev_cnt
);
  import roc_pkg::*;
  // ----------------------------------------------------------------
  // Feeds
  // ----------------------------------------------------------------
  // Blocking follows its command at once.
  assign block_in = blk_cmd;
  assign inv_time = 16'h0005;
  assign meas = '{ratio: ratio_cmd, pickup: 16'h0064, u1: 16'h0BB8, i_fault: 16'h0123,
    i_pre20: 16'h0045, i_pre200: 16'h0067, phases: 4'h7, group: 3'h2};
  // ----------------------------------------------------------------
  // Event buffer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      time_stamp <= '0;
      ev_cnt <= '0;
    end else begin
      time_stamp <= time_stamp + 32'h1;
      for (int k = 0; k < 6; k++) begin
        if (event_o.hits[k]) begin
          ev_cnt[k] <= ev_cnt[k] + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== roc_pkg.sv ====
// Constants, types and register map of the restrained overcurrent stage.
`default_nettype none
package roc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned ROC_CLK_NS = 10;
  localparam int unsigned ROC_PROG_CYCLE_NS = 5000000;
  localparam int unsigned ROC_CYCLE_CLKS = ROC_PROG_CYCLE_NS / ROC_CLK_NS;

  // ----------------------------------------------------------------
  // Sizes and thresholds
  // ----------------------------------------------------------------
  localparam int unsigned ROC_REC_DEPTH = 12;
  localparam int unsigned ROC_CNT_W = 16;
  localparam int unsigned ROC_AW = 8;
  localparam logic [15:0] ROC_PU_ON = 16'h0064;
  localparam logic [15:0] ROC_PU_OFF = 16'h0061;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ROC_A_CTRL = 8'h00;
  localparam logic [7:0] ROC_A_DT = 8'h04;
  localparam logic [7:0] ROC_A_REL = 8'h08;
  localparam logic [7:0] ROC_A_KNEE = 8'h0C;
  localparam logic [7:0] ROC_A_CLR = 8'h10;
  localparam logic [7:0] ROC_A_STAT = 8'h14;
  localparam logic [7:0] ROC_A_EXP = 8'h18;
  localparam logic [7:0] ROC_A_REM = 8'h1C;
  localparam logic [7:0] ROC_A_LVL = 8'h20;
  localparam logic [7:0] ROC_A_RATIO = 8'h24;
  localparam logic [7:0] ROC_A_CNT0 = 8'h28;
  localparam logic [7:0] ROC_A_CNT1 = 8'h2C;
  localparam logic [7:0] ROC_A_CNT2 = 8'h30;
  localparam logic [7:0] ROC_A_RSEL = 8'h34;
  localparam logic [7:0] ROC_A_REC0 = 8'h38;
  localparam logic [7:0] ROC_A_REC1 = 8'h3C;
  localparam logic [7:0] ROC_A_REC2 = 8'h40;
  localparam logic [7:0] ROC_A_REC3 = 8'h44;
  localparam logic [7:0] ROC_A_REC4 = 8'h48;
  localparam logic [7:0] ROC_A_RCNT = 8'h4C;

  // ----------------------------------------------------------------
  // Control field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned ROC_F_MODE = 0;
  localparam int unsigned ROC_F_DLY = 3;
  localparam int unsigned ROC_F_VM = 4;
  localparam int unsigned ROC_F_U0 = 6;
  localparam int unsigned ROC_F_EVM = 8;
  localparam logic [5:0] ROC_EVM_RST = 6'h3F;
  localparam logic [15:0] ROC_DT_RST = 16'h0008;
  localparam logic [15:0] ROC_REL_RST = 16'h0000;
  localparam logic [15:0] ROC_UX1_RST = 16'h07D0;
  localparam logic [15:0] ROC_UX2_RST = 16'h2710;

  // ----------------------------------------------------------------
  // Event bit positions and record event codes
  // ----------------------------------------------------------------
  localparam int unsigned ROC_EV_STA_ON = 0;
  localparam int unsigned ROC_EV_STA_OFF = 1;
  localparam int unsigned ROC_EV_TRP_ON = 2;
  localparam int unsigned ROC_EV_TRP_OFF = 3;
  localparam int unsigned ROC_EV_BLK_ON = 4;
  localparam int unsigned ROC_EV_BLK_OFF = 5;
  localparam logic [2:0] ROC_REC_START = 3'h1;
  localparam logic [2:0] ROC_REC_TRIP = 3'h2;
  localparam logic [2:0] ROC_REC_BLK = 3'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ROC_MODE_ON = 3'h0,
    ROC_MODE_BLOCKED = 3'h1,
    ROC_MODE_TEST = 3'h2,
    ROC_MODE_TEST_BLK = 3'h3,
    ROC_MODE_OFF = 3'h4
  } roc_mode_e;

  typedef enum logic [1:0] {
    ROC_COND_NORMAL = 2'h0,
    ROC_COND_START = 2'h1,
    ROC_COND_TRIP = 2'h2,
    ROC_COND_BLOCKED = 2'h3
  } roc_cond_e;

  typedef enum logic [1:0] {
    ROC_VM_PHASE = 2'h0,
    ROC_VM_3LP4 = 2'h1,
    ROC_VM_2LP2 = 2'h2
  } roc_vmode_e;

  typedef struct packed {
    logic [15:0] ratio;
    logic [15:0] pickup;
    logic [15:0] u1;
    logic [15:0] i_fault;
    logic [15:0] i_pre20;
    logic [15:0] i_pre200;
    logic [3:0] phases;
    logic [2:0] group;
  } roc_meas_s;

  typedef struct packed {
    logic [5:0] hits;
    logic [31:0] stamp;
  } roc_event_s;

  typedef struct packed {
    logic [31:0] stamp;
    logic [2:0] code;
    logic [3:0] phases;
    logic [2:0] group;
    logic [16:0] remain;
    logic [15:0] i_pre20;
    logic [15:0] i_fault;
    logic [15:0] u1;
    logic [15:0] pickup;
    logic [15:0] i_pre200;
  } roc_rec_s;

endpackage
`default_nettype wire

// ==== roc_rec_mem.sv ====
// Fault record store with registered read data.
`default_nettype none
module roc_rec_mem #(
  parameter int unsigned DEPTH = 12,
  parameter int unsigned W = 32,
  parameter int unsigned AW = 4
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

// ==== roc_stage.sv ====
// Status, blocking, timing, event and fault-record logic of the restrained overcurrent stage.
//
// Contract
// [RQ1] Blocking input is sampled once per program cycle, before pick-up evaluation.
// [RQ2] Pick-up without blocking raises start and begins operate timing.
// [RQ3] Pick-up with blocking raises blocked and stops start and trip handling.
// [RQ4] Blocking during start clears start and runs release handling as on drop-off.
// [RQ5] The blocking source asserts blocking at least 5 ms before the delay expires.
// [RQ6] Definite or inverse delay; inverse delay follows current over present pick-up.
// [RQ7] Six time-stamped on and off events for start, trip and blocked.
// [RQ8] Per event a mask selects on, off or both into the event buffer.
// [RQ9] Separate clearable counters for start, trip and blocked occurrences.
// [RQ10] Every on event writes a time-stamped record; newest twelve are kept.
// [RQ11] Record holds time, event, phases, currents, voltage, pick-up, remaining, group.
// [RQ12] Condition reads as exactly one of normal, start, trip, blocked.
// [RQ13] Expected operating time in 5 ms steps, following current in inverse mode.
// [RQ14] Remaining time to trip is signed and counts down in 5 ms steps.
// [RQ15] Flag set when no phase voltages and no residual channel are configured.
// [RQ16] Pick-up level, positive sequence voltage and current ratio readable at 0.01.
// [RQ17] Operating mode reads as on, blocked, test, test-with-blocking or off.
// [RQ18] Pick-up releases only below 97 % of the present pick-up value.
// [RQ19] Rising knee pair restrains pick-up; equal knees give voltage-controlled operation.
// [RQ20] Record measurements and remaining time come from the triggering program cycle.
//
// Local design decisions: the APB register port and the address map.
`default_nettype none
module roc_stage #(
  parameter int unsigned CYCLE_CLKS = roc_pkg::ROC_CYCLE_CLKS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [roc_pkg::ROC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic block_in,
  input wire roc_pkg::roc_meas_s meas,
  input wire logic [15:0] inv_time,
  input wire logic [31:0] time_stamp,
  output logic start_o,
  output logic trip_o,
  output logic blocked_o,
  output roc_pkg::roc_event_s event_o
);
  import roc_pkg::*;

  typedef enum logic [1:0] {
    ROC_ST_IDLE = 2'b00,
    ROC_ST_TIMING = 2'b01,
    ROC_ST_TRIPPED = 2'b10,
    ROC_ST_RELEASE = 2'b11
  } roc_state_e;

  localparam int unsigned RECW = $bits(roc_rec_s);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [2:0] mode_q;
  logic dly_inv_q;
  logic [1:0] vm_q;
  logic u0_q;
  logic [5:0] evm_q;
  logic [15:0] dt_q;
  logic [15:0] rel_q;
  logic [15:0] ux1_q;
  logic [15:0] ux2_q;
  logic [2:0] clr_q;
  logic [3:0] rsel_q;

  // ----------------------------------------------------------------
  // Stage state
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic tick;
  roc_state_e st_q, st_d;
  logic [15:0] el_q, el_d;
  logic [15:0] rc_q, rc_d;
  logic pu_q, pu_d;
  logic blk_q;
  logic [16:0] rem_q;
  logic [16:0] rem_d;
  logic [15:0] exp_t;
  logic blk_now;
  logic blocked_d;
  logic start_d;
  logic trip_d;
  logic mode_off;
  logic no_u1;
  logic [5:0] ev_raw;
  logic rec_we;
  roc_rec_s rec_w;
  roc_rec_s rec_r;
  logic [3:0] wptr_q;
  logic [3:0] rcnt_q;
  logic [3:0] raddr;
  logic [4:0] rtmp;
  logic [ROC_CNT_W-1:0] cnt [3];
  logic [2:0] cnt_inc;

  assign mode_off = (mode_q >= ROC_MODE_OFF);
  assign no_u1 = (vm_q != ROC_VM_PHASE) && !u0_q; // [RQ15]
  assign tick = (tick_cnt_q == CYCLE_CLKS - 1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Pick-up, blocking and timing
  // ----------------------------------------------------------------
  // Blocking is read only at the tick: one value per program cycle.
  assign blk_now = block_in || (mode_q == ROC_MODE_BLOCKED) ||
                   (mode_q == ROC_MODE_TEST_BLK); // [RQ1]
  assign exp_t = dly_inv_q ? inv_time : dt_q; // [RQ6] [RQ13]

  always_comb begin
    pu_d = pu_q;
    if (meas.ratio >= ROC_PU_ON) begin
      pu_d = 1'b1;
    end else if (meas.ratio < ROC_PU_OFF) begin
      pu_d = 1'b0; // [RQ18]
    end
    if ((ux2_q == ux1_q) && (meas.u1 >= ux1_q)) begin
      pu_d = 1'b0; // [RQ19]
    end
    if (mode_off) begin
      pu_d = 1'b0;
    end
  end

  always_comb begin
    st_d = st_q;
    el_d = el_q;
    rc_d = rc_q;
    unique case (st_q)
      ROC_ST_IDLE: begin
        el_d = '0;
        if (pu_d && !blk_now) begin
          st_d = ROC_ST_TIMING; // [RQ2]
        end
      end
      ROC_ST_TIMING: begin
        if (!pu_d || blk_now) begin
          st_d = ROC_ST_RELEASE; // [RQ4]
          rc_d = '0;
        end else begin
          el_d = el_q + 16'h1;
          if ({1'b0, el_q} + 17'h1 >= {1'b0, exp_t}) begin
            st_d = ROC_ST_TRIPPED;
          end
        end
      end
      ROC_ST_TRIPPED: begin
        if (!pu_d || blk_now) begin
          st_d = ROC_ST_IDLE;
          el_d = '0;
        end
      end
      ROC_ST_RELEASE: begin
        if (pu_d && !blk_now) begin
          st_d = ROC_ST_TIMING;
        end else if (rc_q + 16'h1 >= rel_q) begin
          st_d = ROC_ST_IDLE;
          el_d = '0;
        end else begin
          rc_d = rc_q + 16'h1;
        end
      end
    endcase
  end

  assign start_d = (st_d == ROC_ST_TIMING) || (st_d == ROC_ST_TRIPPED);
  assign trip_d = (st_d == ROC_ST_TRIPPED);
  assign blocked_d = pu_d && blk_now; // [RQ3]
  assign rem_d = (st_d == ROC_ST_IDLE) ? 17'h0 :
                 17'({1'b0, exp_t} - {1'b0, el_d}); // [RQ14]

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ROC_ST_IDLE;
      el_q <= '0;
      rc_q <= '0;
      pu_q <= 1'b0;
      blk_q <= 1'b0;
      rem_q <= '0;
      start_o <= 1'b0;
      trip_o <= 1'b0;
      blocked_o <= 1'b0;
    end else if (tick) begin
      st_q <= st_d;
      el_q <= el_d;
      rc_q <= rc_d;
      pu_q <= pu_d;
      blk_q <= blk_now; // [RQ1]
      rem_q <= rem_d;
      start_o <= start_d;
      trip_o <= trip_d;
      blocked_o <= blocked_d;
    end
  end

  // ----------------------------------------------------------------
  // Events, counters and fault records
  // ----------------------------------------------------------------
  assign ev_raw[ROC_EV_STA_ON] = start_d && !start_o;
  assign ev_raw[ROC_EV_STA_OFF] = !start_d && start_o;
  assign ev_raw[ROC_EV_TRP_ON] = trip_d && !trip_o;
  assign ev_raw[ROC_EV_TRP_OFF] = !trip_d && trip_o;
  assign ev_raw[ROC_EV_BLK_ON] = blocked_d && !blocked_o;
  assign ev_raw[ROC_EV_BLK_OFF] = !blocked_d && blocked_o;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      event_o <= '0;
    end else begin
      event_o.hits <= tick ? (ev_raw & evm_q) : 6'h0; // [RQ7] [RQ8]
      event_o.stamp <= time_stamp;
    end
  end

  assign cnt_inc = tick ? {ev_raw[ROC_EV_BLK_ON], ev_raw[ROC_EV_TRP_ON],
                           ev_raw[ROC_EV_STA_ON]} : 3'h0;

  for (genvar g = 0; g < 3; g++) begin : g_cnt
    roc_counter #(.W(ROC_CNT_W)) u_cnt (
      .mclk(mclk),
      .rst(rst),
      .inc(cnt_inc[g]),
      .clr(clr_q[g]),
      .count(cnt[g])
    ); // [RQ9]
  end

  assign rec_we = |cnt_inc; // [RQ10]

  always_comb begin
    rec_w.stamp = time_stamp;
    rec_w.code = cnt_inc[2] ? ROC_REC_BLK : (cnt_inc[1] ? ROC_REC_TRIP : ROC_REC_START);
    rec_w.phases = meas.phases;
    rec_w.group = meas.group;
    rec_w.remain = rem_d; // [RQ20]
    rec_w.i_pre20 = meas.i_pre20;
    rec_w.i_fault = meas.i_fault;
    rec_w.u1 = meas.u1;
    rec_w.pickup = meas.pickup;
    rec_w.i_pre200 = meas.i_pre200; // [RQ11]
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wptr_q <= '0;
      rcnt_q <= '0;
    end else if (rec_we) begin
      wptr_q <= (wptr_q == 4'(ROC_REC_DEPTH - 1)) ? 4'h0 : wptr_q + 4'h1;
      if (rcnt_q != 4'(ROC_REC_DEPTH)) begin
        rcnt_q <= rcnt_q + 4'h1;
      end
    end
  end

  // Selection 0 is the newest record; the oldest is overwritten first.
  always_comb begin
    rtmp = 5'({1'b0, wptr_q} + 5'(ROC_REC_DEPTH) - 5'h1 - {1'b0, rsel_q});
    if (rtmp >= 5'(ROC_REC_DEPTH)) begin
      rtmp = rtmp - 5'(ROC_REC_DEPTH);
    end
    raddr = rtmp[3:0];
  end

  roc_rec_mem #(.DEPTH(ROC_REC_DEPTH), .W(RECW), .AW(4)) u_mem (
    .mclk(mclk),
    .we(rec_we),
    .waddr(wptr_q),
    .wdata(rec_w),
    .raddr(raddr),
    .rdata(rec_r)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic setup;
  logic wr;
  logic hit;
  logic [31:0] rd;

  assign setup = psel && !penable;
  assign wr = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    hit = 1'b1;
    rd = 32'h0;
    unique case (paddr)
      ROC_A_CTRL: rd = {18'h0, evm_q, 1'b0, u0_q, vm_q, dly_inv_q, mode_q};
      ROC_A_DT: rd = {16'h0, dt_q};
      ROC_A_REL: rd = {16'h0, rel_q};
      ROC_A_KNEE: rd = {ux2_q, ux1_q};
      ROC_A_CLR: rd = 32'h0;
      ROC_A_STAT: rd = {25'h0, (ux2_q > ux1_q), no_u1, mode_q,
                        (blocked_o ? ROC_COND_BLOCKED : trip_o ? ROC_COND_TRIP :
                         start_o ? ROC_COND_START : ROC_COND_NORMAL)}; // [RQ12] [RQ17]
      ROC_A_EXP: rd = {16'h0, exp_t}; // [RQ13]
      ROC_A_REM: rd = {{15{rem_q[16]}}, rem_q}; // [RQ14]
      ROC_A_LVL: rd = {meas.u1, meas.pickup}; // [RQ16]
      ROC_A_RATIO: rd = {16'h0, meas.ratio}; // [RQ16]
      ROC_A_CNT0: rd = {16'h0, cnt[0]};
      ROC_A_CNT1: rd = {16'h0, cnt[1]};
      ROC_A_CNT2: rd = {16'h0, cnt[2]};
      ROC_A_RSEL: rd = {28'h0, rsel_q};
      ROC_A_REC0: rd = rec_r.stamp;
      ROC_A_REC1: rd = {rec_r.remain[15:0], 3'h0, rec_r.remain[16], rec_r.group,
                        rec_r.phases, 2'h0, rec_r.code};
      ROC_A_REC2: rd = {rec_r.i_fault, rec_r.i_pre20};
      ROC_A_REC3: rd = {rec_r.i_pre200, rec_r.u1};
      ROC_A_REC4: rd = {16'h0, rec_r.pickup};
      ROC_A_RCNT: rd = {28'h0, rcnt_q};
      default: hit = 1'b0;
    endcase
  end

  // No wait states: the answer is registered in the setup cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit;
      prdata <= (setup && hit && !pwrite) ? rd : 32'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q <= ROC_MODE_ON;
      dly_inv_q <= 1'b0;
      vm_q <= ROC_VM_PHASE;
      u0_q <= 1'b0;
      evm_q <= ROC_EVM_RST;
      dt_q <= ROC_DT_RST;
      rel_q <= ROC_REL_RST;
      ux1_q <= ROC_UX1_RST;
      ux2_q <= ROC_UX2_RST;
      rsel_q <= '0;
    end else if (wr) begin
      unique case (paddr)
        ROC_A_CTRL: begin
          mode_q <= pwdata[ROC_F_MODE +: 3];
          dly_inv_q <= pwdata[ROC_F_DLY];
          vm_q <= pwdata[ROC_F_VM +: 2];
          u0_q <= pwdata[ROC_F_U0];
          evm_q <= pwdata[ROC_F_EVM +: 6];
        end
        ROC_A_DT: dt_q <= pwdata[15:0];
        ROC_A_REL: rel_q <= pwdata[15:0];
        ROC_A_KNEE: begin
          ux1_q <= pwdata[15:0];
          ux2_q <= pwdata[31:16];
        end
        ROC_A_RSEL: rsel_q <= (pwdata[3:0] >= 4'(ROC_REC_DEPTH)) ? 4'h0 : pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clr_q <= '0;
    end else begin
      clr_q <= (wr && (paddr == ROC_A_CLR)) ? pwdata[2:0] : 3'h0; // [RQ9]
    end
  end

endmodule
`default_nettype wire

// ==== roc_stage_monitor.sv ====
// Port checks of the restrained overcurrent stage.
`default_nettype none
module roc_stage_monitor #(
  parameter int unsigned CYCLE_CLKS = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start_o,
  input wire logic trip_o,
  input wire logic blocked_o,
  input wire roc_pkg::roc_event_s event_o
);
  import roc_pkg::*;
  logic [2:0] lvl_q;
  logic [31:0] gap_q;
  wire logic [2:0] lvl = {start_o, trip_o, blocked_o};
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Saturating, so a quiet spell cannot wrap to a false failure.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lvl_q <= '0;
      gap_q <= '1;
    end else begin
      lvl_q <= lvl;
      gap_q <= (lvl != lvl_q) ? '0 : ((gap_q == '1) ? gap_q : gap_q + 32'h1);
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready missing after setup"); // Bus.
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready"); // Bus.
  property p_gap; (lvl != lvl_q) |-> gap_q >= 32'(CYCLE_CLKS - 1); endproperty
  a_gap: assert property (p_gap) else $error("output changed between ticks");
  property p_sta_on; event_o.hits[0] |-> start_o && !$past(start_o); endproperty
  a_sta_on: assert property (p_sta_on) else $error("start event without start");
  property p_trip_src; $rose(trip_o) |-> $past(start_o) && !blocked_o; endproperty
  a_trip_src: assert property (p_trip_src) else $error("trip without start");
  property p_excl; blocked_o |-> !start_o && !trip_o; endproperty
  a_excl: assert property (p_excl) else $error("blocked with start or trip");
  property p_sta_off; event_o.hits[1] |-> $fell(start_o); endproperty
  a_sta_off: assert property (p_sta_off) else $error("start off event mismatch");
  property p_trp_ev;
    (event_o.hits[2] |-> $rose(trip_o)) and (event_o.hits[3] |-> $fell(trip_o));
  endproperty
  a_trp_ev: assert property (p_trp_ev) else $error("trip event mismatch");
  property p_blk_ev;
    (event_o.hits[4] |-> $rose(blocked_o)) and (event_o.hits[5] |-> $fell(blocked_o));
  endproperty
  a_blk_ev: assert property (p_blk_ev) else $error("block event mismatch");
  property p_pulse; (event_o.hits != 6'h00) |=> event_o.hits == 6'h00 [*3]; endproperty
  a_pulse: assert property (p_pulse) else $error("event hit too long");
  c_start: cover property ($rose(start_o));
  c_trip: cover property ($rose(trip_o));
  c_blk: cover property ($rose(blocked_o));
endmodule
bind roc_stage roc_stage_monitor #(.CYCLE_CLKS(CYCLE_CLKS)) u_mon (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
  .event_o(event_o)
);
`default_nettype wire

// ==== roc_stage_tb_top.sv ====
// Self-checking testbench of the restrained overcurrent stage.
`default_nettype none
module roc_stage_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import roc_pkg::*;
  localparam int unsigned CC = 8;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, time_stamp;
  logic blk_cmd, block_in, start_o, trip_o, blocked_o;
  logic [15:0] ratio_cmd, inv_time;
  logic [5:0][7:0] ev_cnt;
  roc_meas_s meas;
  roc_event_s event_o;
  int error_cnt, checked;
  roc_stage #(.CYCLE_CLKS(CC)) dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .block_in(block_in), .meas(meas), .inv_time(inv_time),
    .time_stamp(time_stamp), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
    .event_o(event_o));
  roc_partner u_far (.mclk(mclk), .rst(rst), .blk_cmd(blk_cmd), .ratio_cmd(ratio_cmd),
    .event_o(event_o), .block_in(block_in), .meas(meas), .inv_time(inv_time),
    .time_stamp(time_stamp), .ev_cnt(ev_cnt));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic ticks(input int n);
    repeat (n * CC) @(posedge mclk);
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rdchk(ROC_A_CTRL, 32'h3F00);
    rdchk(ROC_A_KNEE, 32'h2710_07D0);
    rdchk(ROC_A_STAT, 32'h40);
    rdchk(ROC_A_REM, 32'h0);
    rdchk(ROC_A_LVL, 32'h0BB8_0064);
    apb(1'b0, 8'hFC, 32'h0);
    chk({rd[31:1], err}, 32'h1); // Unmapped address is refused.
  endtask
  task automatic t_trip;
    apb(1'b1, ROC_A_DT, 32'h3);
    rdchk(ROC_A_EXP, 32'h3);
    ratio_cmd <= 16'h0078;
    ticks(2);
    chk({31'h0, start_o}, 32'h1);
    apb(1'b0, ROC_A_REM, 32'h0);
    chk({31'h0, $signed(rd) > 0 && $signed(rd) <= 3}, 32'h1);
    rdchk(ROC_A_REC2, 32'h0123_0045);
    apb(1'b0, ROC_A_REC1, 32'h0);
    chk({20'h0, rd[11:0]}, {20'h0, 3'h2, 4'h7, 2'h0, ROC_REC_START});
    ticks(4);
    chk({31'h0, trip_o}, 32'h1);
    rdchk(ROC_A_STAT, 32'h42);
    rdchk(ROC_A_CNT1, 32'h1);
    ratio_cmd <= 16'h0061;
    ticks(2);
    chk({30'h0, start_o, trip_o}, 32'h3);
    ratio_cmd <= 16'h0060;
    ticks(2);
    chk({30'h0, start_o, trip_o}, 32'h0);
    chk(ev_cnt[3:0], 32'h0101_0101);
    apb(1'b1, ROC_A_DT, 32'h8);
  endtask
  task automatic t_block;
    ratio_cmd <= 16'h0078;
    ticks(2);
    blk_cmd <= 1'b1;
    ticks(2);
    chk({29'h0, start_o, trip_o, blocked_o}, 32'h1);
    rdchk(ROC_A_STAT, 32'h43);
    rdchk(ROC_A_CNT2, 32'h1);
    ratio_cmd <= '0;
    ticks(2);
    ratio_cmd <= 16'h0078;
    ticks(3);
    chk({29'h0, start_o, trip_o, blocked_o}, 32'h1);
    rdchk(ROC_A_RCNT, 32'h5);
    blk_cmd <= 1'b0;
    ratio_cmd <= '0;
    ticks(2);
    apb(1'b1, ROC_A_CLR, 32'h7);
    rdchk(ROC_A_CNT0, 32'h0);
    rdchk(ROC_A_CNT2, 32'h0);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, ROC_A_CTRL, 32'h3F00 | 32'(m));
      apb(1'b0, ROC_A_STAT, 32'h0);
      chk({29'h0, rd[4:2]}, 32'(m));
    end
    ratio_cmd <= 16'h0078;
    ticks(2);
    chk({31'h0, start_o}, 32'h0);
    ratio_cmd <= '0;
    apb(1'b1, ROC_A_CTRL, 32'h3F10);
    apb(1'b0, ROC_A_STAT, 32'h0);
    chk({31'h0, rd[5]}, 32'h1);
    apb(1'b1, ROC_A_CTRL, 32'h3F50);
    apb(1'b0, ROC_A_STAT, 32'h0);
    chk({31'h0, rd[5]}, 32'h0);
    apb(1'b1, ROC_A_CTRL, 32'h3F08);
    rdchk(ROC_A_EXP, 32'h5);
    ratio_cmd <= 16'h0078;
    ticks(7);
    chk({31'h0, trip_o}, 32'h1);
    ratio_cmd <= '0;
    apb(1'b1, ROC_A_CTRL, 32'h3F00);
    apb(1'b1, ROC_A_KNEE, 32'h07D0_07D0);
    ratio_cmd <= 16'h0078;
    ticks(3);
    chk({31'h0, start_o}, 32'h0);
    ratio_cmd <= '0;
    apb(1'b1, ROC_A_KNEE, 32'h2710_07D0);
  endtask
  task automatic t_mask_rec;
    logic [5:0][7:0] e0;
    apb(1'b1, ROC_A_CTRL, 32'h0200);
    e0 = ev_cnt;
    for (int i = 0; i < 13; i++) begin
      ratio_cmd <= 16'h0078;
      ticks(2);
      ratio_cmd <= '0;
      ticks(2);
    end
    chk({16'h0, ev_cnt[1], ev_cnt[0]}, {16'h0, e0[1] + 8'd13, e0[0]});
    rdchk(ROC_A_RCNT, 32'hC);
    apb(1'b1, ROC_A_RSEL, 32'hC);
    rdchk(ROC_A_RSEL, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Runs take under a thousand cycles; this only trips on a hang.
  initial begin
    #200000;
    error_cnt++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    blk_cmd = 1'b0;
    ratio_cmd = '0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_trip();
    t_block();
    t_modes();
    t_mask_rec();
    tally_and_finish();
  end
endmodule
`default_nettype wire
